// file: shared/ebc_pkg.sv
// Constants and types of the external bus cycle sequencer.
// Assumes users reference every item as ebc_pkg::name.
package ebc_pkg;

    // ----------------------------------------------------------------
    // Bus widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int WINDOW_LSB = 16;
    localparam int CNT_W = 6;

    // ----------------------------------------------------------------
    // Phase length encodings, in phase time units
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_SETUP_MIN = 6'h01;
    localparam logic [5:0] ONE_UNIT = 6'h01;
    localparam logic [5:0] ZERO_UNITS = 6'h00;

    // ----------------------------------------------------------------
    // Timing limits
    // ----------------------------------------------------------------
    localparam real MAX_SYSTEM_FREQ_MHZ = 80.0;
    localparam real MIN_TRANSITION_NS = 12.5;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_CMD = 8'h04,
        ST_WSETUP = 8'h08,
        ST_ACCESS = 8'h10,
        ST_READY = 8'h20,
        ST_HOLD = 8'h40,
        ST_DONE = 8'h80
    } seq_state_t;

endpackage

// file: core/stream_buffer.sv
// Small valid/ready FIFO carrying finished bus cycles to the user.
// Assumes a single clock; in and out sides follow valid/ready rules.
`timescale 1ns/10ps
module stream_buffer #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
            $error("stream_buffer: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [PW:0] count_q, count_d;
    logic push, pop;

    assign in_ready = (count_q != (PW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_d = mem_q;
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d = count_q;
        if (push) begin
            mem_d[wr_ptr_q] = in_data;
            wr_ptr_d = wr_ptr_q + 1'b1;
        end
        if (pop) begin
            rd_ptr_d = rd_ptr_q + 1'b1;
        end
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        mem_q <= mem_d;
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
        end
    end
endmodule

// file: core/external_bus_controller.sv
// External bus controller: runs one user request at a time as a
// five-phase bus cycle on the link clock, which is also sent out.
// Assumes the user side on clk, the pins on link_clk.
//
// Operation
// - Every access runs address setup, command delay, write setup, access, hold.
// - Phase lengths come from the selected chip select's timing config.
// - Address setup is 1-2 units, plus 0-3 when the window changes.
// - Command delay 0-3 units; access phase 1-32 units.
// - Write setup / turnaround phase lasts 0 or 1 unit.
// - Hold phase keeps address and write data for 0-3 units.
// - If enabled, READY from the module stretches the access phase.
// - Link period at least 12.5 ns, i.e. at most 80 MHz.
// - Read data captured on the edge that ends the read strobe.
// - Early address change in separate mode does not spoil the read.
// - Reference clock output is the bus clock itself.
// - Shared mode: address then write data on shared lines; else data lines.
// - READY polarity selectable per chip select.
// - Synchronous READY, aligned to reference clock, gives shortest cycle.
// - Asynchronous READY passes an extra stage, one more wait state.
// - Inactive READY inserts a wait state; active READY ends the access phase.
`timescale 1ns/10ps
module external_bus_controller #(
    parameter int CS_COUNT = 4,
    parameter real LINK_PERIOD_NS = 30.0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_high_byte,
    input wire logic [$clog2(CS_COUNT)-1:0] req_cs,
    input wire logic [ebc_pkg::ADDR_W-1:0] req_addr,
    input wire logic [ebc_pkg::DATA_W-1:0] req_wdata,
    output logic resp_valid,
    input wire logic resp_ready,
    output logic resp_was_write,
    output logic [ebc_pkg::DATA_W-1:0] resp_rdata,
    output logic busy,
    input wire logic [CS_COUNT-1:0] cfg_addr_setup_long,
    input wire logic [CS_COUNT-1:0][1:0] cfg_window_extra,
    input wire logic [CS_COUNT-1:0][1:0] cfg_command_delay,
    input wire logic [CS_COUNT-1:0] cfg_write_setup,
    input wire logic [CS_COUNT-1:0][4:0] cfg_access_len,
    input wire logic [CS_COUNT-1:0][1:0] cfg_final_hold,
    input wire logic [CS_COUNT-1:0] cfg_ready_enable,
    input wire logic [CS_COUNT-1:0] cfg_ready_async,
    input wire logic [CS_COUNT-1:0] cfg_ready_active_high,
    input wire logic [CS_COUNT-1:0] cfg_shared_bus_mode,
    output logic reference_clock_out,
    output logic [ebc_pkg::ADDR_W-1:0] address_lines,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic high_byte_select_n,
    output logic [CS_COUNT-1:0] cs_n,
    input wire logic ready_pin,
    input wire logic [ebc_pkg::DATA_W-1:0] data_lines_in,
    output logic [ebc_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    input wire logic [ebc_pkg::DATA_W-1:0] shared_bus_lines_in,
    output logic [ebc_pkg::DATA_W-1:0] shared_bus_lines_out,
    output logic shared_bus_lines_oe
);
    localparam int CS_W = $clog2(CS_COUNT);
    localparam int AW = ebc_pkg::ADDR_W;
    localparam int DW = ebc_pkg::DATA_W;
    localparam int CW = ebc_pkg::CNT_W;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    generate
        if (CS_COUNT < 2) begin : g_bad_cs
            $error("external_bus_controller: CS_COUNT must be at least 2");
        end
        if (LINK_PERIOD_NS < ebc_pkg::MIN_TRANSITION_NS) begin : g_bad_period
            $error("external_bus_controller: link period below transition limit");
        end
    endgenerate

    assign reference_clock_out = link_clk;

    // ----------------------------------------------------------------
    // User side: request hold registers and response handshake
    // ----------------------------------------------------------------
    logic outstanding_q, outstanding_d, req_tgl_q, req_tgl_d, pend_q, pend_d;
    logic h_write_q, h_write_d, h_hi_q, h_hi_d;
    logic [CS_W-1:0] h_cs_q, h_cs_d;
    logic [AW-1:0] h_addr_q, h_addr_d;
    logic [DW-1:0] h_wdata_q, h_wdata_d;
    logic rs1_q, rs2_q, rs3_q;
    logic req_fire, resp_edge, buf_in_ready, buf_push;
    logic [DW-1:0] resp_data_q, resp_data_d;
    logic resp_tgl_q, resp_tgl_d;

    assign req_ready = !outstanding_q;
    assign busy = outstanding_q;
    assign req_fire = req_valid && !outstanding_q;
    assign resp_edge = rs2_q ^ rs3_q;
    assign buf_push = pend_q && buf_in_ready;

    always_comb begin
        outstanding_d = outstanding_q;
        req_tgl_d = req_tgl_q;
        pend_d = pend_q;
        h_write_d = h_write_q;
        h_hi_d = h_hi_q;
        h_cs_d = h_cs_q;
        h_addr_d = h_addr_q;
        h_wdata_d = h_wdata_q;
        if (req_fire) begin
            outstanding_d = 1'b1;
            req_tgl_d = !req_tgl_q;
            h_write_d = req_write;
            h_hi_d = req_high_byte;
            h_cs_d = req_cs;
            h_addr_d = req_addr;
            h_wdata_d = req_wdata;
        end
        if (buf_push) begin
            outstanding_d = 1'b0;
            pend_d = 1'b0;
        end
        if (resp_edge) begin
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        rs1_q <= resp_tgl_q;
        rs2_q <= rs1_q;
        h_write_q <= h_write_d;
        h_hi_q <= h_hi_d;
        h_cs_q <= h_cs_d;
        h_addr_q <= h_addr_d;
        h_wdata_q <= h_wdata_d;
        if (!rst_n) begin
            outstanding_q <= 1'b0;
            req_tgl_q <= 1'b0;
            pend_q <= 1'b0;
            rs3_q <= 1'b0;
        end else begin
            outstanding_q <= outstanding_d;
            req_tgl_q <= req_tgl_d;
            pend_q <= pend_d;
            rs3_q <= rs2_q;
        end
    end

    // Receiver stall holds up to two cycle results here, then blocks requests
    stream_buffer #(
        .WIDTH(DW + 1),
        .DEPTH(2)
    ) u_resp_buffer (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(pend_q),
        .in_ready(buf_in_ready),
        .in_data({h_write_q, resp_data_q}),
        .out_valid(resp_valid),
        .out_ready(resp_ready),
        .out_data({resp_was_write, resp_rdata})
    );

    // ----------------------------------------------------------------
    // Link side synchronisers
    // ----------------------------------------------------------------
    logic lr1_q, lr2_q, qs1_q, qs2_q, qs3_q, rd1_q, rd2_q, rd3_q;
    logic new_req;

    always_ff @(posedge link_clk) begin
        lr1_q <= rst_n;
        lr2_q <= lr1_q;
        qs1_q <= req_tgl_q;
        qs2_q <= qs1_q;
        qs3_q <= qs2_q;
        rd1_q <= ready_pin;
        rd2_q <= rd1_q;
        rd3_q <= rd2_q;
    end
    assign new_req = qs2_q ^ qs3_q;

    // ----------------------------------------------------------------
    // Cycle sequencer
    // ----------------------------------------------------------------
    localparam int WINDOW_LSB_P = ebc_pkg::WINDOW_LSB;

    ebc_pkg::seq_state_t state_q, state_d;
    ebc_pkg::seq_state_t after_addr, after_cmd, after_access, after_ready;
    logic [CW-1:0] cnt_q, cnt_d, as_len, cmd_len, hold_len;
    logic [AW-1:WINDOW_LSB_P] last_win_q, last_win_d;
    logic [CS_W-1:0] last_cs_q, last_cs_d;
    logic win_valid_q, win_valid_d, win_change;
    logic rdy_en, rdy_level, rdy_active, shared, strobe_end;
    logic [DW-1:0] cap_q, cap_d;

    assign cmd_len = CW'(cfg_command_delay[h_cs_q]);
    assign hold_len = CW'(cfg_final_hold[h_cs_q]);
    assign rdy_en = cfg_ready_enable[h_cs_q];
    assign shared = cfg_shared_bus_mode[h_cs_q];
    assign win_change = !win_valid_q || (h_addr_q[AW-1:WINDOW_LSB_P] != last_win_q) || (h_cs_q != last_cs_q);
    assign as_len = ebc_pkg::ADDR_SETUP_MIN + CW'(cfg_addr_setup_long[h_cs_q])
        + (win_change ? CW'(cfg_window_extra[h_cs_q]) : ebc_pkg::ZERO_UNITS);
    // sync READY uses two stages only
    assign rdy_level = cfg_ready_async[h_cs_q] ? rd3_q : rd2_q;
    assign rdy_active = cfg_ready_active_high[h_cs_q] ? rdy_level : !rdy_level;

    assign after_ready = (hold_len != ebc_pkg::ZERO_UNITS) ? ebc_pkg::ST_HOLD : ebc_pkg::ST_DONE;
    // READY takes over after access count
    assign after_access = rdy_en ? ebc_pkg::ST_READY : after_ready;
    assign after_cmd = cfg_write_setup[h_cs_q] ? ebc_pkg::ST_WSETUP : ebc_pkg::ST_ACCESS;
    assign after_addr = (cmd_len != ebc_pkg::ZERO_UNITS) ? ebc_pkg::ST_CMD : after_cmd;

    assign strobe_end = ((state_q == ebc_pkg::ST_ACCESS) && (cnt_q == '0) && !rdy_en)
        || ((state_q == ebc_pkg::ST_READY) && rdy_active);

    function automatic logic [CW-1:0] load_of(input ebc_pkg::seq_state_t s, input logic [CW-1:0] c_len,
                                              input logic [4:0] acc, input logic [CW-1:0] h_len);
        case (s)
            ebc_pkg::ST_CMD: load_of = c_len - ebc_pkg::ONE_UNIT;
            // access field holds length minus one
            ebc_pkg::ST_ACCESS: load_of = CW'(acc);
            ebc_pkg::ST_HOLD: load_of = h_len - ebc_pkg::ONE_UNIT;
            default: load_of = '0;
        endcase
    endfunction

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        last_win_d = last_win_q;
        last_cs_d = last_cs_q;
        win_valid_d = win_valid_q;
        cap_d = cap_q;
        resp_data_d = resp_data_q;
        resp_tgl_d = resp_tgl_q;
        case (state_q)
            ebc_pkg::ST_IDLE: begin
                if (new_req) begin
                    state_d = ebc_pkg::ST_ADDR;
                    cnt_d = as_len - ebc_pkg::ONE_UNIT;
                    last_win_d = h_addr_q[AW-1:WINDOW_LSB_P];
                    last_cs_d = h_cs_q;
                    win_valid_d = 1'b1;
                end
            end
            ebc_pkg::ST_ADDR, ebc_pkg::ST_CMD, ebc_pkg::ST_WSETUP, ebc_pkg::ST_ACCESS, ebc_pkg::ST_HOLD: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    case (state_q)
                        ebc_pkg::ST_ADDR: state_d = after_addr;
                        ebc_pkg::ST_CMD: state_d = after_cmd;
                        ebc_pkg::ST_WSETUP: state_d = ebc_pkg::ST_ACCESS;
                        // READY looked at only from here on
                        ebc_pkg::ST_ACCESS: state_d = after_access;
                        default: state_d = ebc_pkg::ST_DONE;
                    endcase
                    cnt_d = load_of(state_d, cmd_len, cfg_access_len[h_cs_q], hold_len);
                end
            end
            ebc_pkg::ST_READY: begin
                if (rdy_active) begin
                    state_d = after_ready;
                    cnt_d = load_of(state_d, cmd_len, cfg_access_len[h_cs_q], hold_len);
                end
            end
            ebc_pkg::ST_DONE: begin
                resp_data_d = cap_q;
                resp_tgl_d = !resp_tgl_q;
                state_d = ebc_pkg::ST_IDLE;
            end
            default: state_d = ebc_pkg::ST_IDLE;
        endcase
        if (strobe_end && !h_write_q) begin
            cap_d = shared ? shared_bus_lines_in : data_lines_in;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!lr2_q) begin
            state_q <= ebc_pkg::ST_IDLE;
            cnt_q <= '0;
            last_win_q <= '0;
            last_cs_q <= '0;
            win_valid_q <= 1'b0;
            cap_q <= '0;
            resp_data_q <= '0;
            resp_tgl_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            last_win_q <= last_win_d;
            last_cs_q <= last_cs_d;
            win_valid_q <= win_valid_d;
            cap_q <= cap_d;
            resp_data_q <= resp_data_d;
            resp_tgl_q <= resp_tgl_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers, registered from the next state
    // ----------------------------------------------------------------
    logic active, strobe, addr_ph, data_ph;
    logic [CS_COUNT-1:0] cs_sel, cs_n_d;
    logic [AW-1:0] addr_d;
    logic ale_d, rd_n_d, wr_n_d, bhe_n_d, dat_oe_d, sh_oe_d;
    logic [DW-1:0] sh_o_d;

    genvar gi;
    generate
        for (gi = 0; gi < CS_COUNT; gi++) begin : g_cs
            assign cs_sel[gi] = (h_cs_q == CS_W'(gi));
            assign cs_n_d[gi] = !(active && cs_sel[gi]);
        end
    endgenerate

    assign active = (state_d != ebc_pkg::ST_IDLE) && (state_d != ebc_pkg::ST_DONE);
    assign strobe = (state_d == ebc_pkg::ST_ACCESS) || (state_d == ebc_pkg::ST_READY);
    assign addr_ph = (state_d == ebc_pkg::ST_ADDR) || (state_d == ebc_pkg::ST_CMD);
    // write data held through hold phase
    assign data_ph = active && !addr_ph && h_write_q;

    always_comb begin
        addr_d = active ? h_addr_q : address_lines;
        ale_d = (state_d == ebc_pkg::ST_ADDR);
        rd_n_d = !(strobe && !h_write_q);
        wr_n_d = !(strobe && h_write_q);
        bhe_n_d = !(active && h_hi_q);
        // shared lines: address, then write data
        sh_oe_d = shared && active && (addr_ph || data_ph);
        sh_o_d = addr_ph ? h_addr_q[DW-1:0] : h_wdata_q;
        // turnaround leaves shared lines released on reads
        dat_oe_d = !shared && data_ph;
    end

    always_ff @(posedge link_clk) begin
        if (!lr2_q) begin
            address_lines <= '0;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            high_byte_select_n <= 1'b1;
            cs_n <= '1;
            data_lines_out <= '0;
            data_lines_oe <= 1'b0;
            shared_bus_lines_out <= '0;
            shared_bus_lines_oe <= 1'b0;
        end else begin
            address_lines <= addr_d;
            ale <= ale_d;
            rd_n <= rd_n_d;
            wr_n <= wr_n_d;
            high_byte_select_n <= bhe_n_d;
            cs_n <= cs_n_d;
            data_lines_out <= h_wdata_q;
            data_lines_oe <= dat_oe_d;
            shared_bus_lines_out <= sh_o_d;
            shared_bus_lines_oe <= sh_oe_d;
        end
    end
endmodule

// file: sim/ebc_bus_checker_assertions.sv
// Pin-level checker for the bus cycle sequencer, bound to its top module.
// Assumes cfg ports stay static from request to finished bus cycle.
`timescale 1ns/10ps
module ebc_bus_checker #(
    parameter int CS_COUNT = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic [CS_COUNT-1:0] cfg_addr_setup_long,
    input wire logic [CS_COUNT-1:0][1:0] cfg_window_extra,
    input wire logic [CS_COUNT-1:0][1:0] cfg_command_delay,
    input wire logic [CS_COUNT-1:0] cfg_write_setup,
    input wire logic [CS_COUNT-1:0][4:0] cfg_access_len,
    input wire logic [CS_COUNT-1:0][1:0] cfg_final_hold,
    input wire logic [CS_COUNT-1:0] cfg_ready_enable,
    input wire logic [CS_COUNT-1:0] cfg_ready_async,
    input wire logic reference_clock_out,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [CS_COUNT-1:0] cs_n,
    input wire logic data_lines_oe,
    input wire logic shared_bus_lines_oe
);
    // ----------------------------------------
    // Phase run lengths in link cycles
    // ----------------------------------------
    int idx_q, ale_q, gap_q, str_q, hold_q;
    wire strobe_off = rd_n && wr_n;
    always_ff @(posedge link_clk) begin
        if (!rst_n) begin
            idx_q <= 0;
            ale_q <= 0;
            gap_q <= 0;
            str_q <= 0;
            hold_q <= 0;
        end else begin
            // Keeps the last select, since cs_n may rise with the strobe
            for (int i = 0; i < CS_COUNT; i++) begin
                if (!cs_n[i]) begin
                    idx_q <= i;
                end
            end
            ale_q <= ale ? ale_q + 1 : 0;
            gap_q <= ale ? 0 : (strobe_off ? gap_q + 1 : gap_q);
            str_q <= strobe_off ? 0 : str_q + 1;
            hold_q <= !strobe_off ? 0 : ((&cs_n) ? hold_q : hold_q + 1);
        end
    end
    a_refclk_follows: assert property (@(posedge clk) disable iff (!rst_n)
        reference_clock_out == link_clk) else $error("refclk differs from link clock");
    a_addr_setup_len: assert property (@(posedge link_clk) disable iff (!rst_n)
        $fell(ale) |-> ale_q >= 1 + cfg_addr_setup_long[idx_q]
        && ale_q <= 1 + cfg_addr_setup_long[idx_q] + cfg_window_extra[idx_q]) else $error("bad ale length");
    a_cmd_gap_len: assert property (@(posedge link_clk) disable iff (!rst_n)
        $fell(strobe_off) |-> gap_q == cfg_command_delay[idx_q] + cfg_write_setup[idx_q])
        else $error("bad gap before strobe");
    a_access_len: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(strobe_off) |-> (cfg_ready_enable[idx_q] ? str_q > cfg_access_len[idx_q]
        : str_q == cfg_access_len[idx_q] + 1)) else $error("bad strobe length");
    a_async_wait: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(strobe_off) && cfg_ready_enable[idx_q] && cfg_ready_async[idx_q]
        |-> str_q > cfg_access_len[idx_q] + 1) else $error("async ready lacks wait");
    a_hold_len: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(&cs_n) |-> hold_q == cfg_final_hold[idx_q]) else $error("bad hold length");
    a_read_released: assert property (@(posedge link_clk) disable iff (!rst_n)
        !rd_n |-> !shared_bus_lines_oe && !data_lines_oe) else $error("lines driven during read");
    a_write_driven: assert property (@(posedge link_clk) disable iff (!rst_n)
        !wr_n |-> shared_bus_lines_oe || data_lines_oe) else $error("write data not driven");
    c_read: cover property (@(posedge link_clk) $rose(rd_n));
    c_write: cover property (@(posedge link_clk) $rose(wr_n));
    c_ready: cover property (@(posedge link_clk) $rose(strobe_off) && cfg_ready_enable[idx_q]);
endmodule

bind external_bus_controller ebc_bus_checker #(.CS_COUNT(CS_COUNT)) chk_i (.*);

// file: sim/bus_memory_model.sv
// Word memory behind the bus pins, answering with a READY handshake.
// Assumes the bench sets READY delay and polarity before each request.
`timescale 1ns/10ps
module bus_memory_model (
    input wire logic reference_clock_out,
    input wire logic [23:0] address_lines,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic high_byte_select_n,
    input wire logic [15:0] data_lines_out,
    input wire logic data_lines_oe,
    input wire logic [15:0] shared_bus_lines_out,
    input wire logic shared_bus_lines_oe,
    input wire logic [1:0] rdy_wait,
    input wire logic rdy_pol,
    output logic ready_pin,
    output logic [15:0] data_lines_in,
    output logic [15:0] shared_bus_lines_in,
    output logic [23:0] seen_addr,
    output logic seen_hbs_n
);
    logic [15:0] mem [int];
    logic [15:0] word_q = 16'h0000;
    logic [15:0] junk_q = 16'h0000;
    int wait_q = 0;
    wire [23:0] pin_addr = {address_lines[23:16], shared_bus_lines_oe ? shared_bus_lines_out : address_lines[15:0]};
    // junk once the strobe is gone
    assign data_lines_in = rd_n ? junk_q : word_q;
    assign shared_bus_lines_in = rd_n ? ~junk_q : word_q;
    initial ready_pin = 1'b0;
    always @(posedge reference_clock_out) begin
        junk_q <= {junk_q[14:0], ~junk_q[15]};
        if (ale) begin
            seen_addr <= pin_addr;
            seen_hbs_n <= high_byte_select_n;
            word_q <= mem.exists(pin_addr) ? mem[pin_addr] : pin_addr[15:0] ^ 16'h5A5A;
        end
        if (!wr_n) begin
            mem[seen_addr] = data_lines_oe ? data_lines_out : shared_bus_lines_out;
        end
        // READY on refclk after rdy_wait units
        wait_q <= (rd_n && wr_n) ? 0 : wait_q + 1;
        ready_pin <= (!(rd_n && wr_n) && wait_q >= rdy_wait) ? rdy_pol : !rdy_pol;
    end
endmodule

// file: sim/tb_external_bus_cycle_sequencer.sv
// Bench for the bus cycle sequencer: random cycles, then a response stall.
// Assumes bus_memory_model on the pins and the bound pin checker.
`timescale 1ns/10ps
module tb_external_bus_cycle_sequencer;
    localparam int N = 4;
    logic clk = 0, rst_n = 0, link_clk = 0, req_valid = 0, req_write = 0, req_high_byte = 0, resp_ready = 1;
    logic req_ready, resp_valid, resp_was_write, busy, reference_clock_out, ale, rd_n, wr_n;
    logic high_byte_select_n, ready_pin, data_lines_oe, shared_bus_lines_oe, rdy_pol = 0, seen_hbs_n;
    logic [1:0] req_cs = '0, rdy_wait = '0;
    logic [23:0] req_addr = '0, address_lines, seen_addr;
    logic [15:0] req_wdata = '0, resp_rdata, data_lines_in, data_lines_out, shared_bus_lines_in, shared_bus_lines_out;
    logic [N-1:0] cfg_addr_setup_long = '0, cfg_write_setup = '0, cfg_ready_enable = '0, cfg_ready_async = '0;
    logic [N-1:0] cfg_ready_active_high = '0, cfg_shared_bus_mode = '0, cs_n;
    logic [N-1:0][1:0] cfg_window_extra = '0, cfg_command_delay = '0, cfg_final_hold = '0;
    logic [N-1:0][4:0] cfg_access_len = '0;
    logic [31:0] rng = 32'h5A;
    logic [15:0] mem [int];
    logic [16:0] expq [$];
    int n_mismatch = 0, comparisons = 0;

    always #2 clk = ~clk;
    always #15 link_clk = ~link_clk;

    external_bus_controller #(.CS_COUNT(N), .LINK_PERIOD_NS(30.0)) dut (.*);
    bus_memory_model far_i (.*);

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // First pass all minimum, second all maximum, then random
    task automatic set_cfg(input int i);
        logic [31:0] r0, r1;
        r0 = rnd();
        r1 = rnd();
        if (i < 2) begin
            r0 = {32{i[0]}};
            r1 = r0;
        end
        cfg_addr_setup_long <= r0[3:0];
        cfg_write_setup <= r0[7:4];
        cfg_ready_enable <= r0[11:8];
        cfg_ready_async <= r0[15:12];
        cfg_ready_active_high <= r0[19:16];
        cfg_shared_bus_mode <= r0[23:20];
        cfg_window_extra <= r0[31:24];
        cfg_command_delay <= r1[7:0];
        cfg_final_hold <= r1[15:8];
        cfg_access_len <= {r1[31:16], r0[3:0]};
        rdy_wait <= r1[17:16];
    endtask

    task automatic send(input logic w, input logic [1:0] cs, input logic [23:0] a, input logic [15:0] d,
        input logic hb);
        int k;
        expq.push_back({w, w ? d : (mem.exists(a) ? mem[a] : a[15:0] ^ 16'h5A5A)});
        if (w) mem[a] = d;
        rdy_pol <= cfg_ready_active_high[cs];
        req_valid <= 1'b1;
        req_write <= w;
        req_cs <= cs;
        req_addr <= a;
        req_wdata <= d;
        req_high_byte <= hb;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 3000);
        if (req_ready !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
        req_valid <= 1'b0;
        // Lets an edge pass so a following call does not re-raise valid in this step
        @(posedge clk);
    endtask

    task automatic collect();
        int k;
        logic [16:0] e;
        e = expq.pop_front();
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!(resp_valid === 1'b1 && resp_ready === 1'b1) && k < 3000);
        if (k >= 3000) begin
            n_mismatch++;
            report_and_stop();
        end
        chk(32'(resp_was_write), 32'(e[16]));
        if (!e[16]) chk(32'(resp_rdata), 32'(e[15:0]));
    endtask

    initial begin
        logic [31:0] r;
        logic [23:0] a;
        // Long enough for the link side to see reset too
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge link_clk);
        @(posedge clk);
        for (int i = 0; i < 40; i++) begin
            set_cfg(i);
            @(posedge clk);
            r = rnd();
            a = {7'h00, r[3], 12'h000, r[7:4]};
            send(r[0], r[2:1], a, r[23:8], r[24]);
            collect();
            chk(32'(seen_addr), 32'(a));
            chk(32'(seen_hbs_n), 32'(!r[24]));
        end
        $display("test random_cycles done");
        resp_ready <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            r = rnd();
            send(1'b0, r[1:0], {8'h01, r[17:2]}, 16'h0000, 1'b0);
        end
        repeat (600) @(posedge clk);
        chk(32'(busy), 32'h1);
        chk(32'(req_ready), 32'h0);
        resp_ready <= 1'b1;
        repeat (3) collect();
        $display("test buffer_stall done");
        report_and_stop();
    end
endmodule
